// >>> hdl/msl_bank.sv
// Module status and latched-fault register bank with host register port.
`include "msl_consts.svh"

module msl_bank #(
    parameter int LANE_COUNT = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port
    input wire msl_pkg::msl_addr_t addr_i,
    input wire msl_pkg::msl_word_t wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output msl_pkg::msl_word_t rdata_o,
    // Module-level status pins
    input wire logic skew_misalign_i,
    input wire logic pm_interval_done_i,
    input wire logic high_power_on_flag_i,
    input wire logic host_side_lock_loss_i,
    input wire logic line_side_lock_loss_i,
    input wire logic cooling_interlock_i,
    input wire logic reference_clock_input_loss_i,
    input wire logic jitter_pll_lock_loss_i,
    input wire logic tx_clock_multiplier_lock_loss_i,
    input wire logic init_fault_i,
    input wire logic power_supply_fault_i,
    input wire logic checksum_fault_i,
    // Per-lane status pins, bit n belongs to lane n
    input wire logic [15:0] lane_cooler_fault_i,
    input wire logic [15:0] wavelength_unlock_i,
    input wire logic [15:0] photodiode_supply_fault_i,
    input wire logic [15:0] tx_signal_fault_i,
    input wire logic [15:0] tx_lane_lock_loss_i,
    input wire logic [15:0] rx_signal_loss_i,
    input wire logic [15:0] rx_lane_lock_loss_i,
    input wire logic [15:0] rx_fifo_status_i,
    input wire logic [15:0] rx_cooler_fault_i,
    // Summary status and interrupt
    output logic tx_signal_fault_o,
    output logic rx_signal_loss_o,
    output logic irq_o
);

    // ============================================================
    // Input synchronisation
    localparam int MW = 12;
    localparam int SW = MW + 9 * 16;

    logic [SW-1:0] raw_w;
    logic [SW-1:0] stb_w;
    logic [15:0] l_cool;
    logic [15:0] l_wave;
    logic [15:0] l_pds;
    logic [15:0] l_txf;
    logic [15:0] l_txl;
    logic [15:0] l_rxs;
    logic [15:0] l_rxl;
    logic [15:0] l_fifo;
    logic [15:0] l_rxc;
    logic [MW-1:0] m_w;
    logic [15:0] lane_on;

    assign raw_w = {lane_cooler_fault_i, wavelength_unlock_i,
        photodiode_supply_fault_i, tx_signal_fault_i, tx_lane_lock_loss_i,
        rx_signal_loss_i, rx_lane_lock_loss_i, rx_fifo_status_i,
        rx_cooler_fault_i, skew_misalign_i, pm_interval_done_i,
        high_power_on_flag_i, host_side_lock_loss_i, line_side_lock_loss_i,
        cooling_interlock_i, reference_clock_input_loss_i,
        jitter_pll_lock_loss_i, tx_clock_multiplier_lock_loss_i,
        init_fault_i, power_supply_fault_i, checksum_fault_i};

    msl_sync3 #(.W(SW)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(raw_w),
        .stable_o(stb_w)
    );

    assign {l_cool, l_wave, l_pds, l_txf, l_txl, l_rxs, l_rxl, l_fifo,
        l_rxc, m_w} = stb_w;

    // Lanes beyond the built count are masked out of every sum and latch.
    genvar gi;
    generate
        for (gi = 0; gi < `MSL_LANE_MAX; gi++)
        begin : g_on
            assign lane_on[gi] = (gi < LANE_COUNT);
        end
    endgenerate

    // Module-level signals, named after the packing order above.
    logic s_skew, s_pm, s_hipwr, s_hlol, s_nlol, s_ilk;
    logic s_ref, s_jit, s_cmu, s_init, s_psu, s_csum;
    assign {s_skew, s_pm, s_hipwr, s_hlol, s_nlol, s_ilk, s_ref, s_jit,
        s_cmu, s_init, s_psu, s_csum} = m_w;

    // ============================================================
    // Lane summaries
    logic txf_any;
    logic rxs_any;
    logic txf_r;
    logic rxs_r;
    logic hlol_prev_r;
    logic nlol_prev_r;

    assign txf_any = |(l_txf & lane_on);
    assign rxs_any = |(l_rxs & lane_on);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            txf_r <= 1'b0;
            rxs_r <= 1'b0;
            hlol_prev_r <= 1'b0;
            nlol_prev_r <= 1'b0;
        end
        else
        begin
            txf_r <= txf_any;
            rxs_r <= rxs_any;
            hlol_prev_r <= s_hlol;
            nlol_prev_r <= s_nlol;
        end
    end

    assign tx_signal_fault_o = txf_r;
    assign rx_signal_loss_o = rxs_r;

    // ============================================================
    // Address decode
    logic hit_cur, hit_gen, hit_flt, hit_ist, hit_imk, hit_lane;
    msl_pkg::msl_lane_idx_t lane_idx;
    msl_pkg::msl_addr_t lane_off;

    assign lane_off = addr_i - `MSL_ADDR_LANE_BASE;
    assign lane_idx = lane_off[3:0];
    assign hit_cur = (addr_i == `MSL_ADDR_GEN_CUR);
    assign hit_gen = (addr_i == `MSL_ADDR_GEN_LATCH);
    assign hit_flt = (addr_i == `MSL_ADDR_FAULT_LATCH);
    assign hit_ist = (addr_i == `MSL_ADDR_IRQ_STAT);
    assign hit_imk = (addr_i == `MSL_ADDR_IRQ_MASK);
    assign hit_lane = (lane_off[15:4] == 12'h000);

    // ============================================================
    // Current general status word
    msl_pkg::msl_word_t gen_cur;
    always_comb
    begin
        gen_cur = `MSL_RESET_WORD;
        gen_cur[`MSL_GEN_SKEW] = s_skew;
        gen_cur[`MSL_GEN_HIPWR] = s_hipwr;
        gen_cur[`MSL_GEN_PMDONE] = s_pm;
    end

    // ============================================================
    // General and module fault latches
    msl_pkg::msl_word_t gen_set, flt_set, gen_q, flt_q;
    always_comb
    begin
        gen_set = `MSL_RESET_WORD;
        gen_set[`MSL_GEN_TXFAULT] = txf_any ^ txf_r;
        gen_set[`MSL_GEN_HOST_LOL] = s_hlol ^ hlol_prev_r;
        gen_set[`MSL_GEN_RXLOS] = rxs_any ^ rxs_r;
        gen_set[`MSL_GEN_LINE_LOL] = s_nlol ^ nlol_prev_r;
        gen_set[`MSL_GEN_INTERLOCK] = s_ilk;
        gen_set[`MSL_GEN_REFERENCE_CLOCK_INPUT] = s_ref;
        gen_set[`MSL_GEN_JITTER] = s_jit;
        gen_set[`MSL_GEN_CMU] = s_cmu;
        gen_set[`MSL_GEN_SKEW] = s_skew;
        gen_set[`MSL_GEN_PMDONE] = s_pm;
        flt_set = `MSL_RESET_WORD;
        flt_set[`MSL_FLT_INIT] = s_init;
        flt_set[`MSL_FLT_POWER] = s_psu;
        flt_set[`MSL_FLT_CHECKSUM] = s_csum;
    end

    // Reads clear the latch; a new set in that cycle still lands.
    msl_sticky u_gen (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(gen_set),
        .keep_i(`MSL_MASK_GEN_LATCH),
        .clr_i(re_i & hit_gen),
        .q_o(gen_q)
    );

    msl_sticky u_flt (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(flt_set),
        .keep_i(`MSL_MASK_FAULT),
        .clr_i(re_i & hit_flt),
        .q_o(flt_q)
    );

    // ============================================================
    // Lane latches
    msl_pkg::msl_word_t lane_q [0:15];
    logic [15:0] lane_evt;

    generate
        for (gi = 0; gi < `MSL_LANE_MAX; gi++)
        begin : g_lane
            msl_pkg::msl_word_t set_w;
            always_comb
            begin
                set_w = `MSL_RESET_WORD;
                set_w[`MSL_LANE_COOLER] = l_cool[gi];
                set_w[`MSL_LANE_WAVE] = l_wave[gi];
                set_w[`MSL_LANE_PDSUP] = l_pds[gi];
                set_w[`MSL_LANE_TXFAULT] = l_txf[gi];
                set_w[`MSL_LANE_TXLOL] = l_txl[gi];
                set_w[`MSL_LANE_RXLOS] = l_rxs[gi];
                set_w[`MSL_LANE_RXLOL] = l_rxl[gi];
                set_w[`MSL_LANE_FIFO] = l_fifo[gi];
                set_w[`MSL_LANE_RXCOOL] = l_rxc[gi];
                set_w = set_w & {16{lane_on[gi]}};
            end
            assign lane_evt[gi] = |set_w;
            msl_sticky u_lane (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .set_i(set_w),
                .keep_i(`MSL_MASK_LANE & {16{lane_on[gi]}}),
                .clr_i(re_i & hit_lane & (lane_idx == gi)),
                .q_o(lane_q[gi])
            );
        end
    endgenerate

    // ============================================================
    // Interrupt status and mask
    msl_pkg::msl_word_t ist_r, imk_r, ist_set;
    always_comb
    begin
        ist_set = `MSL_RESET_WORD;
        ist_set[`MSL_IRQ_GEN] = |gen_set;
        ist_set[`MSL_IRQ_FAULT] = |flt_set;
        ist_set[`MSL_IRQ_LANE] = |lane_evt;
    end

    // Events keep firing while a level fault persists, so the status
    // bit re-arms right after a clearing read until the cause goes.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ist_r <= `MSL_RESET_WORD;
        else if (re_i && hit_ist)
            ist_r <= ist_set;
        else
            ist_r <= ist_r | ist_set;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            imk_r <= `MSL_RESET_WORD;
        else if (we_i && hit_imk)
            imk_r <= wdata_i & `MSL_MASK_IRQ;
    end

    assign irq_o = |(ist_r & imk_r);

    // ============================================================
    // Read data, valid only in the cycle after the read strobe
    msl_pkg::msl_word_t rdata_r;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_r <= `MSL_RESET_WORD;
        else if (!re_i)
            rdata_r <= `MSL_RESET_WORD;
        else if (hit_cur)
            rdata_r <= gen_cur;
        else if (hit_gen)
            rdata_r <= gen_q;
        else if (hit_flt)
            rdata_r <= flt_q;
        else if (hit_ist)
            rdata_r <= ist_r;
        else if (hit_imk)
            rdata_r <= imk_r;
        else if (hit_lane)
            rdata_r <= lane_q[lane_idx];
        else
            rdata_r <= `MSL_RESET_WORD;
    end

    assign rdata_o = rdata_r;

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_skew_cur;
        re_i && hit_cur |=> rdata_o[`MSL_GEN_SKEW] == $past(s_skew);
    endproperty
    a_skew_cur: assert property (p_skew_cur)
        else $error("skew status bit wrong");

    property p_cur_bits;
        re_i && hit_cur |=> rdata_o[`MSL_GEN_HIPWR] == $past(s_hipwr)
            && rdata_o[`MSL_GEN_PMDONE] == $past(s_pm)
            && (rdata_o & ~`MSL_MASK_GEN_CUR) == 16'h0000;
    endproperty
    a_cur_bits: assert property (p_cur_bits)
        else $error("general status bits wrong");

    property p_edge_latch;
        $changed(txf_r) |-> gen_q[`MSL_GEN_TXFAULT];
    endproperty
    a_edge_latch: assert property (p_edge_latch)
        else $error("transmit fault change not latched");

    property p_level_latch;
        s_ilk && !(re_i && hit_gen) |=> gen_q[`MSL_GEN_INTERLOCK];
    endproperty
    a_level_latch: assert property (p_level_latch)
        else $error("interlock not latched");

    property p_gen_reserved;
        (gen_q & ~`MSL_MASK_GEN_LATCH) == 16'h0000;
    endproperty
    a_gen_reserved: assert property (p_gen_reserved)
        else $error("reserved general latch bit set");

    property p_read_clear;
        re_i && hit_gen && gen_set == 16'h0000 |=> gen_q == 16'h0000;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("latch not cleared by read");

    property p_hold;
        !(re_i && hit_flt) && flt_q[`MSL_FLT_POWER]
            |=> flt_q[`MSL_FLT_POWER] [*2] or (re_i && hit_flt);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latch bit lost without read");

    property p_flt_reserved;
        (flt_q & ~`MSL_MASK_FAULT) == 16'h0000;
    endproperty
    a_flt_reserved: assert property (p_flt_reserved)
        else $error("reserved fault latch bit set");

    property p_lane_read;
        re_i && hit_lane |=> rdata_o == $past(lane_q[lane_idx]);
    endproperty
    a_lane_read: assert property (p_lane_read)
        else $error("lane read returned wrong word");

    property p_lane_reserved;
        (lane_q[0] & ~`MSL_MASK_LANE) == 16'h0000;
    endproperty
    a_lane_reserved: assert property (p_lane_reserved)
        else $error("reserved lane latch bit set");

    property p_tx_or;
        ##1 tx_signal_fault_o == $past(|(l_txf & lane_on));
    endproperty
    a_tx_or: assert property (p_tx_or)
        else $error("transmit fault summary wrong");

    property p_rx_or;
        (|(l_rxs & lane_on)) |=> rx_signal_loss_o;
    endproperty
    a_rx_or: assert property (p_rx_or)
        else $error("receive loss summary wrong");

    property p_set_wins;
        re_i && hit_flt |=> (flt_q & $past(flt_set)) == $past(flt_set);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost in clearing read");

    // A fault event with its mask bit already open must raise the line
    // on the next edge, whatever the state of the other sources.
    property p_irq;
        |flt_set && imk_r[`MSL_IRQ_FAULT] && !(we_i && hit_imk) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output mismatch");

    c_gen_read: cover property (re_i && hit_gen ##1 rdata_o != 16'h0000);
    c_lane_read: cover property (re_i && hit_lane ##1 rdata_o != 16'h0000);
    c_set_in_clear: cover property (re_i && hit_flt && flt_set != 16'h0000);
    c_irq: cover property ($rose(irq_o));

endmodule

// >>> hdl/msl_consts.svh
// Register offsets, field positions, masks and reset values of the bank.
`ifndef MSL_CONSTS_SVH
`define MSL_CONSTS_SVH

// ============================================================
// Register offsets
`define MSL_ADDR_GEN_CUR 16'hb022
`define MSL_ADDR_GEN_LATCH 16'hb023
`define MSL_ADDR_FAULT_LATCH 16'hb024
`define MSL_ADDR_IRQ_STAT 16'hb0f0
`define MSL_ADDR_IRQ_MASK 16'hb0f1
`define MSL_ADDR_LANE_BASE 16'hb1d0
`define MSL_LANE_MAX 16
`define MSL_RESET_WORD 16'h0000

// ============================================================
// General status bit positions
`define MSL_GEN_HIPWR 1
`define MSL_GEN_PMDONE 2
`define MSL_GEN_SKEW 3
`define MSL_GEN_LINE_LOL 4
`define MSL_GEN_RXLOS 5
`define MSL_GEN_HOST_LOL 6
`define MSL_GEN_TXFAULT 7
`define MSL_GEN_CMU 8
`define MSL_GEN_JITTER 9
`define MSL_GEN_REFERENCE_CLOCK_INPUT 10
`define MSL_GEN_INTERLOCK 13

// ============================================================
// Module fault latch bit positions
`define MSL_FLT_CHECKSUM 1
`define MSL_FLT_POWER 5
`define MSL_FLT_INIT 6

// ============================================================
// Lane latch bit positions
`define MSL_LANE_RXCOOL 1
`define MSL_LANE_FIFO 2
`define MSL_LANE_RXLOL 3
`define MSL_LANE_RXLOS 4
`define MSL_LANE_TXLOL 6
`define MSL_LANE_TXFAULT 7
`define MSL_LANE_PDSUP 13
`define MSL_LANE_WAVE 14
`define MSL_LANE_COOLER 15

// ============================================================
// Implemented-bit masks; all other bits read zero
`define MSL_MASK_GEN_CUR 16'h000e
`define MSL_MASK_GEN_LATCH 16'h27fc
`define MSL_MASK_FAULT 16'h0062
`define MSL_MASK_LANE 16'he0de
`define MSL_MASK_IRQ 16'h0007

// ============================================================
// Interrupt status bit positions
`define MSL_IRQ_GEN 0
`define MSL_IRQ_FAULT 1
`define MSL_IRQ_LANE 2

`endif

// >>> hdl/msl_pkg.sv
// Types shared by the status latch bank files.
package msl_pkg;
    typedef logic [15:0] msl_word_t;
    typedef logic [15:0] msl_addr_t;
    typedef logic [3:0] msl_lane_idx_t;
endpackage

// >>> hdl/msl_sync3.sv
// Three-stage input synchroniser that accepts a change once stages agree.
module msl_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] stable_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;

    // ============================================================
    // Synchroniser chain
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A bit moves only while the last two stages agree, so a single
    // disagreeing sample cannot toggle the output.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            out_r <= '0;
        else
            out_r <= (s2_r & s3_r) | (out_r & (s2_r | s3_r));
    end

    assign stable_o = out_r;

endmodule

// >>> hdl/msl_sticky.sv
// Sticky latch word: bits set by events, whole word cleared by a read.
module msl_sticky (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Control
    input wire msl_pkg::msl_word_t set_i,
    input wire msl_pkg::msl_word_t keep_i,
    input wire logic clr_i,
    // State
    output msl_pkg::msl_word_t q_o
);
`include "msl_consts.svh"

    msl_pkg::msl_word_t q_r;

    // ============================================================
    // Latch word
    // A set in the clearing cycle survives; keep_i forces unused bits low.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            q_r <= `MSL_RESET_WORD;
        else
            q_r <= (set_i | (q_r & {16{~clr_i}})) & keep_i;
    end

    assign q_o = q_r;

endmodule

// >>> verif/msl_host_model.sv
// Host management controller model that drives the bank's register port.
module msl_host_model (
    // Clock
    input wire logic clk_i,
    // Register port
    output msl_pkg::msl_addr_t addr_o,
    output msl_pkg::msl_word_t wdata_o,
    output logic we_o,
    output logic re_o,
    input wire msl_pkg::msl_word_t rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
        we_o = 1'b0;
        re_o = 1'b0;
    end

    // ============================================================
    // Bus cycles
    // The address is inverted once a strobe drops, so a slave that decodes
    // outside the strobe cycle sees a wrong address rather than a held one.
    task automatic wr(input msl_pkg::msl_addr_t a,
                      input msl_pkg::msl_word_t d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        we_o <= 1'b1;
        @(posedge clk_i);
        we_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic rd(input msl_pkg::msl_addr_t a,
                      output msl_pkg::msl_word_t d);
        @(posedge clk_i);
        addr_o <= a;
        re_o <= 1'b1;
        @(posedge clk_i);
        re_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the status latch bank.
`include "msl_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LC = 12;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    msl_pkg::msl_addr_t addr;
    msl_pkg::msl_word_t wdata;
    msl_pkg::msl_word_t rdata;
    logic we, re, txo, rxo, irq;
    logic skew, pmd, hip, hll, lll, ilk, rcl, jit, cmu, ini, pwr, cks;
    logic [15:0] lc, wu, pd, txf, txl, rxs, rxl, fifo, rxc;
    int error_cnt = 0;
    int n_tests = 0;

    always #10 clk_i = ~clk_i;

    // ============================================================
    // Design and host model
    msl_bank #(.LANE_COUNT(LC)) dut_u (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
        .rdata_o(rdata),
        .skew_misalign_i(skew), .pm_interval_done_i(pmd),
        .high_power_on_flag_i(hip),
        .host_side_lock_loss_i(hll), .line_side_lock_loss_i(lll),
        .cooling_interlock_i(ilk), .reference_clock_input_loss_i(rcl),
        .jitter_pll_lock_loss_i(jit), .tx_clock_multiplier_lock_loss_i(cmu),
        .init_fault_i(ini), .power_supply_fault_i(pwr),
        .checksum_fault_i(cks),
        .lane_cooler_fault_i(lc), .wavelength_unlock_i(wu),
        .photodiode_supply_fault_i(pd), .tx_signal_fault_i(txf),
        .tx_lane_lock_loss_i(txl), .rx_signal_loss_i(rxs),
        .rx_lane_lock_loss_i(rxl), .rx_fifo_status_i(fifo),
        .rx_cooler_fault_i(rxc),
        .tx_signal_fault_o(txo), .rx_signal_loss_o(rxo), .irq_o(irq)
    );

    msl_host_model host_u (
        .clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
        .we_o(we), .re_o(re), .rdata_i(rdata)
    );

    // ============================================================
    // Helpers
    function automatic msl_pkg::msl_word_t lane_word(input logic [8:0] p);
        return {p[8:6], 5'h00, p[5:4], 1'b0, p[3:0], 1'b0};
    endfunction

    task automatic chk(input string n, input msl_pkg::msl_word_t e,
                       input msl_pkg::msl_word_t g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdc(input msl_pkg::msl_addr_t a,
                       input msl_pkg::msl_word_t e);
        msl_pkg::msl_word_t d;
        host_u.rd(a, d);
        chk($sformatf("register %h", a), e, d);
    endtask

    // Long enough for the synchroniser and latch to follow a pin change.
    task automatic gap;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic set_lane(input int n, input logic [8:0] p);
        @(posedge clk_i);
        {lc[n], wu[n], pd[n], txf[n], txl[n]} <= p[8:4];
        {rxs[n], rxl[n], fifo[n], rxc[n]} <= p[3:0];
        gap();
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        msl_pkg::msl_word_t g;
        msl_pkg::msl_addr_t la;
        logic [8:0] p;
        logic [6:0] s;
        {skew, pmd, hip, hll, lll, ilk, rcl, jit, cmu, ini, pwr, cks} = '0;
        {lc, wu, pd, txf, txl, rxs, rxl, fifo, rxc} = '0;
        void'($urandom(32'h577b38e5));
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdc(`MSL_ADDR_GEN_LATCH, 16'h0000);
        rdc(`MSL_ADDR_FAULT_LATCH, 16'h0000);
        rdc(`MSL_ADDR_LANE_BASE, 16'h0000);
        rdc(`MSL_ADDR_GEN_CUR, 16'h0000);
        for (int k = 0; k < 6; k++)
        begin
            s = (k == 0) ? 7'h7f : 7'($urandom);
            @(posedge clk_i);
            {ilk, rcl, jit, cmu, skew, pmd, hip} <= s;
            {ini, pwr, cks} <= s[2:0];
            gap();
            rdc(`MSL_ADDR_GEN_CUR, {12'h000, s[2:0], 1'b0});
            @(posedge clk_i);
            {ilk, rcl, jit, cmu, skew, pmd, hip} <= 7'h00;
            {ini, pwr, cks} <= 3'h0;
            gap();
            rdc(`MSL_ADDR_GEN_CUR, 16'h0000);
            rdc(`MSL_ADDR_GEN_LATCH,
                {2'b0, s[6], 2'b0, s[5:3], 4'h0, s[2:1], 2'b0});
            rdc(`MSL_ADDR_GEN_LATCH, 16'h0000);
            rdc(`MSL_ADDR_FAULT_LATCH,
                {9'h000, s[2:1], 3'h0, s[0], 1'b0});
        end
        // Both edges of the lock-loss signals must latch, a steady level not.
        @(posedge clk_i);
        {hll, lll} <= 2'b11;
        gap();
        rdc(`MSL_ADDR_GEN_LATCH, 16'h0050);
        gap();
        rdc(`MSL_ADDR_GEN_LATCH, 16'h0000);
        @(posedge clk_i);
        {hll, lll} <= 2'b00;
        gap();
        rdc(`MSL_ADDR_GEN_LATCH, 16'h0050);
        @(posedge clk_i);
        ilk <= 1'b1;
        gap();
        rdc(`MSL_ADDR_GEN_LATCH, 16'h2000);
        rdc(`MSL_ADDR_GEN_LATCH, 16'h2000);
        @(posedge clk_i);
        ilk <= 1'b0;
        gap();
        rdc(`MSL_ADDR_GEN_LATCH, 16'h2000);
        rdc(`MSL_ADDR_GEN_LATCH, 16'h0000);
        for (int n = 0; n < 16; n++)
        begin
            p = (n == 0 || n == 15) ? 9'h1ff : 9'($urandom);
            set_lane(n, p);
            chk("tx summary", 16'(p[5] && n < LC), 16'(txo));
            chk("rx summary", 16'(p[3] && n < LC), 16'(rxo));
            set_lane(n, 9'h000);
            la = `MSL_ADDR_LANE_BASE + 16'(n);
            g = (n < LC) ? lane_word(p) : 16'h0000;
            rdc(la, g);
            rdc(la, 16'h0000);
            g = (n < LC) ? {8'h00, p[5], 1'b0, p[3], 5'h00} : 16'h0000;
            rdc(`MSL_ADDR_GEN_LATCH, g);
        end
        // Every source has fired by now and nothing has read the status.
        rdc(`MSL_ADDR_IRQ_STAT, 16'h0007);
        host_u.wr(`MSL_ADDR_IRQ_MASK, 16'h0002);
        rdc(`MSL_ADDR_IRQ_MASK, 16'h0002);
        chk("irq idle", 16'h0000, {15'h0, irq});
        @(posedge clk_i);
        pwr <= 1'b1;
        gap();
        pwr <= 1'b0;
        gap();
        chk("irq raised", 16'h0001, {15'h0, irq});
        host_u.wr(`MSL_ADDR_IRQ_MASK, 16'h0000);
        @(negedge clk_i);
        chk("irq masked", 16'h0000, {15'h0, irq});
        host_u.wr(`MSL_ADDR_IRQ_MASK, 16'h0002);
        @(negedge clk_i);
        chk("irq unmasked", 16'h0001, {15'h0, irq});
        rdc(`MSL_ADDR_IRQ_STAT, 16'h0002);
        @(negedge clk_i);
        chk("irq cleared", 16'h0000, {15'h0, irq});
        rdc(`MSL_ADDR_FAULT_LATCH, 16'h0020);
        host_u.wr(`MSL_ADDR_GEN_LATCH, 16'hffff);
        rdc(`MSL_ADDR_GEN_LATCH, 16'h0000);
        rdc(16'hb100, 16'h0000);
        // The general and lane sources must reach the status, the lane source also the line.
        host_u.wr(`MSL_ADDR_IRQ_MASK, 16'h0004);
        @(posedge clk_i);
        ilk <= 1'b1;
        txf[0] <= 1'b1;
        gap();
        chk("irq lane", 16'h0001, {15'h0, irq});
        ilk <= 1'b0;
        txf[0] <= 1'b0;
        gap();
        rdc(`MSL_ADDR_IRQ_STAT, 16'h0005);
        @(negedge clk_i);
        chk("irq lane cleared", 16'h0000, {15'h0, irq});
        final_report();
    end

    // ============================================================
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        final_report();
    end
endmodule
